/* File: src/tio_map.svh */
// addresses, reset values and fixed-bit masks of the timer pin configuration
`ifndef TIO_MAP_SVH
`define TIO_MAP_SVH

// ****************************************************************
// register addresses (byte addresses on the processor memory bus)
// ****************************************************************
`define TIO_ADDR_FILTER_EN 20'hf0061
`define TIO_ADDR_OUT_MODE_LO 20'hf01be
`define TIO_ADDR_OUT_MODE_HI 20'hf01bf
`define TIO_ADDR_PORT0_DIR 20'hfff20
`define TIO_ADDR_PORT1_DIR 20'hfff21
`define TIO_ADDR_PORT3_DIR 20'hfff23
`define TIO_ADDR_PORT4_DIR 20'hfff24
`define TIO_ADDR_PORT14_DIR 20'hfff2e
`define TIO_ADDR_INPUT_SWITCH 20'hfff3c

// ****************************************************************
// reset values
// ****************************************************************
`define TIO_RST_FILTER_EN 8'h00
`define TIO_RST_OUT_MODE 8'h00
`define TIO_RST_PORT_DIR 8'hff
`define TIO_RST_INPUT_SWITCH 8'h00

// ****************************************************************
// bits that always read as one (port direction) or are writable
// ****************************************************************
`define TIO_FIX1_PORT0 8'h80
`define TIO_FIX1_PORT1 8'h00
`define TIO_FIX1_PORT3 8'hfc
`define TIO_FIX1_PORT4 8'h00
`define TIO_FIX1_PORT14 8'hc0
`define TIO_WMASK_INPUT_SWITCH 8'h03

// ****************************************************************
// field positions
// ****************************************************************
`define TIO_ISW_EXT_IRQ0 0
`define TIO_ISW_CH7 1
`define TIO_CH7 7

`endif

/* File: src/tio_pkg.sv */
// types shared by the timer pin configuration block
package tio_pkg;

  // ****************************************************************
  // processor memory bus
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [19:0] addr;
    logic [7:0] bitmask;
    logic [15:0] wdata;
  } tio_bus_req_s;

  typedef struct packed {
    logic rvalid;
    logic [15:0] rdata;
  } tio_bus_rsp_s;

  // ****************************************************************
  // timer core side
  // ****************************************************************
  typedef struct packed {
    logic [7:0] channel_irq;
    logic [7:0] out_enable_bit;
    logic [7:0] out_level_invert_bit;
    logic out_wr;
    logic [7:0] out_wdata;
  } tio_tmr_in_s;

  // ****************************************************************
  // pins
  // ****************************************************************
  typedef struct packed {
    logic [7:0] timer_in_pin;
    logic serial_rx_pin;
    logic ext_irq0_pin;
  } tio_pins_in_s;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
    logic [7:0] port3;
    logic [7:0] port4;
    logic [7:0] port14;
  } tio_port_byte_s;

  // ****************************************************************
  // state of the whole block
  // ****************************************************************
  typedef struct packed {
    logic [7:0] filter_enable_bit;
    logic [7:0] out_mode_bit;
    logic [7:0] input_switch;
    tio_port_byte_s port_direction_bit;
    tio_port_byte_s port_oe;
    logic [7:0] timer_out;
    logic ext_irq0;
    tio_bus_rsp_s rsp;
  } tio_state_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic out;
  } tio_flt_state_s;

endpackage : tio_pkg

/* File: src/tio_input_filter.sv */
// one timer input: synchroniser with optional two-sample match filter
`timescale 1ns/100ps
module tio_input_filter
  import tio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // input and control
  input wire logic raw_in,
  input wire logic filter_enable_bit,
  // filtered level
  output logic filt_out
);

  tio_flt_state_s state_r;
  tio_flt_state_s state_nxt;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.sync1 = raw_in;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev = state_r.sync2;
    if (!filter_enable_bit)
    begin
      state_nxt.out = state_r.sync2;
    end
    else if (state_r.sync2 == state_r.prev)
    begin
      state_nxt.out = state_r.sync2;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign filt_out = state_r.out;

endmodule : tio_input_filter

/* File: src/tio_config_regs.sv */
// timer pin configuration: output modes, input switch, filters, directions
`timescale 1ns/100ps
`include "tio_map.svh"
module tio_config_regs
  import tio_pkg::*;
#(
  parameter int NUM_CH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // processor memory bus
  input wire tio_bus_req_s bus_req,
  output tio_bus_rsp_s bus_rsp,
  // timer core
  input wire tio_tmr_in_s tmr_in,
  output logic [7:0] timer_out,
  output logic [7:0] filtered_timer_in,
  // pins and external interrupt routing
  input wire tio_pins_in_s pins_in,
  output logic ext_irq0_out,
  output tio_port_byte_s port_oe
);

  tio_state_s state_r;
  tio_state_s state_nxt;

  logic [7:0] master_irq;
  logic [7:0] filt_raw;
  logic [7:0] filt_out;
  logic [7:0] tgl_evt;
  logic [7:0] set_evt;
  logic [7:0] rst_evt;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // masked byte update with fixed-one bits forced
  function automatic logic [7:0] upd_byte(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic [7:0] mask,
    input logic [7:0] fix1
  );
    logic [7:0] res;
    res = (old & ~mask) | (wdata & mask);
    upd_byte = res | fix1;
  endfunction : upd_byte

  // master interrupt seen by each channel; zero when the channel has none
  function automatic logic [7:0] find_master(
    input logic [7:0] mode,
    input logic [7:0] irq
  );
    logic [7:0] res;
    logic done;
    res = 8'h00;
    for (int q = 0; q < 8; q++)
    begin
      done = 1'b0;
      for (int n = 7; n >= 0; n--)
      begin
        if (!done && n < q && !mode[n])
        begin
          done = 1'b1;
          if ((n % 2) == 0)
          begin
            res[q] = irq[n];
          end
        end
      end
    end
    find_master = res;
  endfunction : find_master

  assign master_irq = find_master(state_r.out_mode_bit, tmr_in.channel_irq);

  // ****************************************************************
  // output events per channel
  // ****************************************************************
  // toggle channels react to their own irq only; a combination channel is
  // set by its master's irq and reset by its own, which is the slave irq
  always_comb
  begin
    tgl_evt = 8'h00;
    set_evt = 8'h00;
    rst_evt = 8'h00;
    for (int q = 0; q < NUM_CH; q++)
    begin
      if (!state_r.out_mode_bit[q])
      begin
        tgl_evt[q] = tmr_in.channel_irq[q];
      end
      else
      begin
        set_evt[q] = master_irq[q];
        rst_evt[q] = tmr_in.channel_irq[q];
      end
    end
  end

  // ****************************************************************
  // input routing and filters
  // ****************************************************************
  always_comb
  begin
    filt_raw = pins_in.timer_in_pin;
    if (state_r.input_switch[`TIO_ISW_CH7])
    begin
      filt_raw[`TIO_CH7] = pins_in.serial_rx_pin;
    end
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_filt
      tio_input_filter u_filt (
        .clk(clk),
        .rstn(rstn),
        .raw_in(filt_raw[g]),
        .filter_enable_bit(state_r.filter_enable_bit[g]),
        .filt_out(filt_out[g])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [7:0] bmask;
    logic [7:0] rbyte;
    logic [15:0] rword;
    bmask = bus_req.word ? 8'hff : bus_req.bitmask;
    rbyte = 8'h00;
    rword = 16'h0000;
    state_nxt = state_r;

    // register writes
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        `TIO_ADDR_FILTER_EN:
        begin
          state_nxt.filter_enable_bit = upd_byte(state_r.filter_enable_bit,
            bus_req.wdata[7:0], bmask, 8'h00);
        end
        `TIO_ADDR_OUT_MODE_LO:
        begin
          state_nxt.out_mode_bit = upd_byte(state_r.out_mode_bit,
            bus_req.wdata[7:0], bmask, 8'h00);
        end
        `TIO_ADDR_PORT0_DIR:
        begin
          state_nxt.port_direction_bit.port0 = upd_byte(
            state_r.port_direction_bit.port0, bus_req.wdata[7:0], bmask,
            `TIO_FIX1_PORT0);
        end
        `TIO_ADDR_PORT1_DIR:
        begin
          state_nxt.port_direction_bit.port1 = upd_byte(
            state_r.port_direction_bit.port1, bus_req.wdata[7:0], bmask,
            `TIO_FIX1_PORT1);
        end
        `TIO_ADDR_PORT3_DIR:
        begin
          state_nxt.port_direction_bit.port3 = upd_byte(
            state_r.port_direction_bit.port3, bus_req.wdata[7:0], bmask,
            `TIO_FIX1_PORT3);
        end
        `TIO_ADDR_PORT4_DIR:
        begin
          state_nxt.port_direction_bit.port4 = upd_byte(
            state_r.port_direction_bit.port4, bus_req.wdata[7:0], bmask,
            `TIO_FIX1_PORT4);
        end
        `TIO_ADDR_PORT14_DIR:
        begin
          state_nxt.port_direction_bit.port14 = upd_byte(
            state_r.port_direction_bit.port14, bus_req.wdata[7:0], bmask,
            `TIO_FIX1_PORT14);
        end
        `TIO_ADDR_INPUT_SWITCH:
        begin
          state_nxt.input_switch = upd_byte(state_r.input_switch,
            bus_req.wdata[7:0], bmask & `TIO_WMASK_INPUT_SWITCH,
            8'h00);
        end
        default:
        begin
          // upper byte of output mode and unmapped addresses: no effect
        end
      endcase
    end

    // register reads, answered one cycle later
    unique case (bus_req.addr)
      `TIO_ADDR_FILTER_EN:
      begin
        rbyte = state_r.filter_enable_bit;
      end
      `TIO_ADDR_OUT_MODE_LO:
      begin
        rbyte = state_r.out_mode_bit;
      end
      `TIO_ADDR_PORT0_DIR:
      begin
        rbyte = state_r.port_direction_bit.port0;
      end
      `TIO_ADDR_PORT1_DIR:
      begin
        rbyte = state_r.port_direction_bit.port1;
      end
      `TIO_ADDR_PORT3_DIR:
      begin
        rbyte = state_r.port_direction_bit.port3;
      end
      `TIO_ADDR_PORT4_DIR:
      begin
        rbyte = state_r.port_direction_bit.port4;
      end
      `TIO_ADDR_PORT14_DIR:
      begin
        rbyte = state_r.port_direction_bit.port14;
      end
      `TIO_ADDR_INPUT_SWITCH:
      begin
        rbyte = state_r.input_switch;
      end
      default:
      begin
        // upper output mode byte and unmapped addresses read as zero
        rbyte = 8'h00;
      end
    endcase
    // a word read of the output mode carries a zero upper byte
    rword = {8'h00, rbyte};
    state_nxt.rsp.rvalid = bus_req.rd;
    state_nxt.rsp.rdata = bus_req.rd ? rword : 16'h0000;

    // timer output per channel
    for (int q = 0; q < NUM_CH; q++)
    begin
      if (tmr_in.out_enable_bit[q])
      begin
        if (!state_r.out_mode_bit[q])
        begin
          // toggle: inversion bit plays no part
          if (tgl_evt[q])
          begin
            state_nxt.timer_out[q] = ~state_r.timer_out[q];
          end
        end
        else
        begin
          // simultaneous events: the slave's reset wins
          if (rst_evt[q])
          begin
            state_nxt.timer_out[q] =
              tmr_in.out_level_invert_bit[q];
          end
          else if (set_evt[q])
          begin
            state_nxt.timer_out[q] =
              ~tmr_in.out_level_invert_bit[q];
          end
        end
      end
      else if (tmr_in.out_wr)
      begin
        state_nxt.timer_out[q] = tmr_in.out_wdata[q];
      end
    end

    // external interrupt 0 routing
    if (state_r.input_switch[`TIO_ISW_EXT_IRQ0])
    begin
      // break and sync field widths are measured on the receive pin
      state_nxt.ext_irq0 = pins_in.serial_rx_pin;
    end
    else
    begin
      state_nxt.ext_irq0 = pins_in.ext_irq0_pin;
    end

    // output buffers follow the direction registers
    // fixed bits stay one in the direction, so their buffers stay off
    state_nxt.port_oe = ~state_nxt.port_direction_bit;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r.filter_enable_bit <= `TIO_RST_FILTER_EN;
      state_r.out_mode_bit <= `TIO_RST_OUT_MODE;
      state_r.input_switch <= `TIO_RST_INPUT_SWITCH;
      state_r.port_direction_bit <= {5{`TIO_RST_PORT_DIR}};
      state_r.port_oe <= '0;
      state_r.timer_out <= 8'h00;
      state_r.ext_irq0 <= 1'b0;
      state_r.rsp <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign bus_rsp = state_r.rsp;
  assign timer_out = state_r.timer_out;
  assign filtered_timer_in = filt_out;
  assign ext_irq0_out = state_r.ext_irq0;
  assign port_oe = state_r.port_oe;

endmodule : tio_config_regs

/* File: testbench/tio_config_regs_asserts.sv */
// assertions on the ports of the timer pin configuration block
`timescale 1ns/100ps
`include "tio_map.svh"
module tio_config_regs_asserts
  import tio_pkg::*;
#(
  parameter int NUM_CH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus and timer core
  input wire tio_bus_req_s bus_req,
  input wire tio_bus_rsp_s bus_rsp,
  input wire tio_tmr_in_s tmr_in,
  input wire logic [7:0] timer_out,
  // pins
  input wire tio_pins_in_s pins_in,
  input wire logic ext_irq0_out
);
  // ********
  // shadow of mode and input switch
  // ********
  logic [7:0] mode_r, isw_r, wm, irq, en, tgl;
  logic ext_sel;
  assign wm = bus_req.word ? 8'hff : bus_req.bitmask;
  assign irq = tmr_in.channel_irq;
  assign en = tmr_in.out_enable_bit;
  assign tgl = irq & en & ~mode_r;
  assign ext_sel = isw_r[0] ? pins_in.serial_rx_pin : pins_in.ext_irq0_pin;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      mode_r <= 8'h00;
      isw_r <= 8'h00;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == `TIO_ADDR_OUT_MODE_LO)
        mode_r <= (mode_r & ~wm) | (bus_req.wdata[7:0] & wm);
      if (bus_req.addr == `TIO_ADDR_INPUT_SWITCH)
        isw_r <= (isw_r & ~wm) | (bus_req.wdata[7:0] & wm);
    end
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_req;
    bus_req.rd;
  endsequence
  sequence s_rd_ans;
    bus_rsp.rvalid && bus_rsp.rdata[15:8] == 8'h00;
  endsequence
  a_read_answer: assert property (s_rd_req |=> s_rd_ans)
    else $error("read not answered next cycle");
  a_rd_quiet: assert property (
    !bus_req.rd |=> !bus_rsp.rvalid && bus_rsp.rdata == 16'h0000)
    else $error("read port busy without read");
  a_ext_route: assert property (
    rstn |=> ext_irq0_out == $past(ext_sel))
    else $error("external irq 0 from wrong pin");
  a_toggle_mode: assert property (
    |tgl |=> ((timer_out ^ $past(timer_out)) & $past(tgl)) == $past(tgl))
    else $error("toggle channel did not toggle");
  a_disabled_hold: assert property (
    !tmr_in.out_wr |=> ((timer_out ^ $past(timer_out)) & ~$past(en)) == 0)
    else $error("disabled output moved");
  a_sw_write: assert property (
    tmr_in.out_wr |=>
      ((timer_out ^ $past(tmr_in.out_wdata)) & ~$past(en)) == 8'h00)
    else $error("software output write lost");
  a_sw_ignored: assert property (
    tmr_in.out_wr && irq == 8'h00 |=>
      ((timer_out ^ $past(timer_out)) & $past(en)) == 8'h00)
    else $error("software write changed enabled output");
  a_master_set: assert property (
    mode_r[1:0] == 2'b10 && irq[1:0] == 2'b01 && en[1]
      && !tmr_in.out_level_invert_bit[1] |=> timer_out[1])
    else $error("master irq did not set slave");
  a_reset_wins: assert property (
    mode_r[1:0] == 2'b10 && irq[1:0] == 2'b11 && en[1]
      && !tmr_in.out_level_invert_bit[1] |=> !timer_out[1])
    else $error("set beat reset on slave");
endmodule : tio_config_regs_asserts

/* File: testbench/tio_pin_model.sv */
// levels that the outside world drives onto the timer pins
`timescale 1ns/100ps
module tio_pin_model
  import tio_pkg::*;
(
  // levels chosen by the bench
  input wire logic [7:0] tin,
  input wire logic rx,
  input wire logic ext,
  // pins into the block
  output tio_pins_in_s pins
);
  // timer inputs are driven only from outside
  assign pins = {tin, rx, ext};
endmodule : tio_pin_model

/* File: testbench/test_timer_io_config_regs.sv */
// self-checking bench for the timer pin configuration block
`timescale 1ns/100ps
`include "tio_map.svh"
module test_timer_io_config_regs
  import tio_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rx = 1'b0;
  logic ext = 1'b0;
  logic seen;
  logic ext_irq0_out;
  logic [7:0] tin = 8'h00;
  logic [7:0] timer_out;
  logic [7:0] filtered_timer_in;
  tio_bus_req_s bus_req = '0;
  tio_bus_rsp_s bus_rsp;
  tio_tmr_in_s tmr_in = '0;
  tio_pins_in_s pins_in;
  tio_port_byte_s port_oe;
  int num_errors = 0;
  int checked = 0;
  localparam logic [19:0] ADRS [8] = '{`TIO_ADDR_FILTER_EN,
    `TIO_ADDR_OUT_MODE_LO, `TIO_ADDR_PORT0_DIR, `TIO_ADDR_PORT1_DIR,
    `TIO_ADDR_PORT3_DIR, `TIO_ADDR_PORT4_DIR, `TIO_ADDR_PORT14_DIR,
    `TIO_ADDR_INPUT_SWITCH};
  localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h00};
  localparam logic [7:0] FIX [8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'hfc,
    8'h00, 8'hc0, 8'h00};
  localparam logic [7:0] WM [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h03};

  always #5 clk = ~clk;

  tio_pin_model u_pins (.tin(tin), .rx(rx), .ext(ext), .pins(pins_in));
  tio_config_regs #(.NUM_CH(8)) u_dut (.clk(clk), .rstn(rstn),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .tmr_in(tmr_in),
    .timer_out(timer_out), .filtered_timer_in(filtered_timer_in),
    .pins_in(pins_in), .ext_irq0_out(ext_irq0_out), .port_oe(port_oe));

  task automatic check(input string what, input logic [39:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [19:0] a, input logic [15:0] d,
    input logic [7:0] m = 8'hff, input logic w = 1'b0);
    @(negedge clk);
    bus_req = '{wr: 1'b1, rd: 1'b0, word: w, addr: a, bitmask: m, wdata: d};
    @(negedge clk);
    bus_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    @(negedge clk);
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(negedge clk);
    bus_req.rd = 1'b0;
    check($sformatf("reg %h", a), {bus_rsp.rvalid, bus_rsp.rdata},
      {1'b1, exp});
  endtask : rd

  // one timer event cycle, then the outputs
  task automatic evc(input logic [7:0] m, exp, input logic w = 1'b0,
    input logic [7:0] d = 8'h00);
    @(negedge clk);
    tmr_in.channel_irq = m;
    tmr_in.out_wr = w;
    tmr_in.out_wdata = d;
    @(negedge clk);
    tmr_in.channel_irq = 8'h00;
    tmr_in.out_wr = 1'b0;
    check("outputs", timer_out, exp);
  endtask : evc

  // pulse one input and watch whether it gets through
  task automatic pulse(input logic on_rx, input int ch, len,
    input logic exp);
    seen = 1'b0;
    for (int i = 0; i < len + 8; i++)
    begin
      @(negedge clk);
      if (on_rx)
        rx = i < len;
      else
        tin[ch] = i < len;
      seen = seen | filtered_timer_in[ch];
    end
    check($sformatf("filter %0d", ch), seen, exp);
  endtask : pulse

  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++)
      rd(ADRS[i], RSTV[i]);
    check("port enables", port_oe, 40'h0);
    for (int v = 0; v < 2; v++)
    begin
      for (int i = 0; i < 8; i++)
        wr(ADRS[i], v ? 16'h00ff : 16'h0000);
      for (int i = 0; i < 8; i++)
        rd(ADRS[i], (v ? WM[i] : 8'h00) | FIX[i]);
      check("oe", port_oe, v ? 40'h0 : 40'h7fff03ff3f);
    end
    wr(`TIO_ADDR_OUT_MODE_LO, 16'hff5a, 8'hff, 1'b1);
    rd(`TIO_ADDR_OUT_MODE_LO, 16'h005a);
    wr(`TIO_ADDR_OUT_MODE_LO, 16'h0033);
    wr(`TIO_ADDR_OUT_MODE_HI, 16'h00ff);
    rd(`TIO_ADDR_OUT_MODE_LO, 16'h0033);
    rd(`TIO_ADDR_OUT_MODE_HI, 16'h0000);
    rd(20'h12345, 16'h0000);
    wr(`TIO_ADDR_FILTER_EN, 16'h0000);
    wr(`TIO_ADDR_FILTER_EN, 16'h00ff, 8'h10);
    rd(`TIO_ADDR_FILTER_EN, 16'h0010);
    for (int s = 0; s < 2; s++)
    begin
      wr(`TIO_ADDR_INPUT_SWITCH, 16'(s));
      for (int j = 0; j < 2; j++)
      begin
        {ext, rx} = j ? 2'b01 : 2'b10;
        repeat (2) @(negedge clk);
        check("ext irq 0", ext_irq0_out, s ? rx : ext);
      end
    end
    rx = 1'b0;
    wr(`TIO_ADDR_FILTER_EN, 16'h0000);
    pulse(1'b0, 0, 1, 1'b1);
    wr(`TIO_ADDR_FILTER_EN, 16'h0081);
    pulse(1'b0, 0, 1, 1'b0);
    pulse(1'b0, 0, 3, 1'b1);
    pulse(1'b0, 7, 1, 1'b0);
    wr(`TIO_ADDR_INPUT_SWITCH, 16'h0002);
    pulse(1'b1, 7, 1, 1'b0);
    pulse(1'b1, 7, 3, 1'b1);
    pulse(1'b0, 7, 3, 1'b0);
    wr(`TIO_ADDR_OUT_MODE_LO, 16'h0000);
    evc(8'h00, 8'h5a, 1'b1, 8'h5a);
    tmr_in.out_enable_bit = 8'h0f;
    tmr_in.out_level_invert_bit = 8'h01;
    evc(8'h00, 8'hfa, 1'b1, 8'hff);
    evc(8'h11, 8'hfb);
    tmr_in.out_enable_bit = 8'h00;
    evc(8'h00, 8'h00, 1'b1, 8'h00);
    tmr_in.out_enable_bit = 8'hff;
    tmr_in.out_level_invert_bit = 8'h00;
    wr(`TIO_ADDR_OUT_MODE_LO, 16'h0002);
    check("outputs", timer_out, 8'h00);
    evc(8'h01, 8'h03);
    evc(8'h02, 8'h01);
    evc(8'h01, 8'h02);
    evc(8'h03, 8'h01);
    tmr_in.out_level_invert_bit = 8'h02;
    evc(8'h01, 8'h00);
    evc(8'h02, 8'h02);
    tmr_in.out_level_invert_bit = 8'h00;
    wr(`TIO_ADDR_OUT_MODE_LO, 16'h0004);
    evc(8'h02, 8'h00);
    wr(`TIO_ADDR_OUT_MODE_LO, 16'h0008);
    evc(8'h04, 8'h0c);
    close_out();
  end
endmodule : test_timer_io_config_regs

bind tio_config_regs tio_config_regs_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .tmr_in(tmr_in), .timer_out(timer_out), .pins_in(pins_in),
  .ext_irq0_out(ext_irq0_out));
